// ==== hdl/seq_angle_window.sv ====
// Phase angle comparator: is the operating phasor within a limit angle of the polarizing one
module seq_angle_window
    import seq_dir_pkg::*;
(
    // Phasors
    input wire wide_phasor_t op_in,
    input wire wide_phasor_t pol_in,
    // Limit as cosine, Q1.15, limits of 40 to 90 degrees keep it non-negative
    input wire logic [PH_W-1:0] limit_cos_in,
    // Result
    output logic inside_out
);

    localparam int PW = 2 * (2 * WIDE_W + 2) + 2 * ANG_FRAC + 2;

    logic signed [2*WIDE_W+1:0] dot;
    logic [PW-1:0] lhs;
    logic [PW-1:0] rhs;

    always_comb begin
        dot = (2*WIDE_W+2)'(op_in.re * pol_in.re) + (2*WIDE_W+2)'(op_in.im * pol_in.im);
        // Squared form avoids square roots and arctangents
        lhs = PW'(unsigned'(dot)) * PW'(unsigned'(dot)) << (2 * ANG_FRAC);
        rhs = PW'(limit_cos_in) * PW'(limit_cos_in) * PW'(mag2(op_in)) * PW'(mag2(pol_in));
        // Zero phasor gives zero dot product and never declares
        inside_out = (dot > 0) && (lhs >= rhs);
    end

endmodule

// ==== hdl/seq_dir_pkg.sv ====
// Shared types, constants and helpers of the sequence directional overcurrent element
package seq_dir_pkg;

    // ******************************************************************
    // Widths and phasor types
    // ******************************************************************
    localparam int PH_W = 16;
    localparam int WIDE_W = 24;
    localparam int OP_W = 28;
    localparam int CNT_W = 8;

    typedef struct packed {
        logic signed [PH_W-1:0] re;
        logic signed [PH_W-1:0] im;
    } phasor_t;

    // Headroom for the offset-compensated voltage and the rotated current
    typedef struct packed {
        logic signed [WIDE_W-1:0] re;
        logic signed [WIDE_W-1:0] im;
    } wide_phasor_t;

    typedef struct packed {
        logic fwd;
        logic rev;
    } dir_pair_t;

    typedef enum logic [0:0] {
        SEQ_NEG = 1'b0,
        SEQ_ZERO = 1'b1
    } seq_mode_t;

    typedef enum logic [1:0] {
        REV_IDLE = 2'b01,
        REV_ARMED = 2'b10
    } rev_state_t;

    // ******************************************************************
    // Scaling
    // ******************************************************************
    localparam logic [OP_W-3:0] K_SCALE = 26'h00003e8;
    localparam int Z_SHIFT = 8;
    localparam int ANG_FRAC = 15;

    // ******************************************************************
    // Timing, counted in phasor samples
    // ******************************************************************
    localparam int SAMPLES_PER_CYCLE = 64;
    localparam int REV_ARM_CYCLES_X100 = 125;
    localparam int FWD_DELAY_CYCLES_X100 = 150;
    // Arming time rounds up, forward delay rounds down
    localparam logic [CNT_W-1:0] REV_ARM_COUNT =
        CNT_W'((SAMPLES_PER_CYCLE * REV_ARM_CYCLES_X100 + 99) / 100);
    localparam logic [CNT_W-1:0] FWD_DELAY_COUNT =
        CNT_W'((SAMPLES_PER_CYCLE * FWD_DELAY_CYCLES_X100) / 100);

    // ******************************************************************
    // Reset values
    // ******************************************************************
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
    localparam dir_pair_t DIR_RESET = 2'h0;

    function automatic logic [2*WIDE_W:0] mag2(input wide_phasor_t p);
        mag2 = (2*WIDE_W+1)'(p.re * p.re) + (2*WIDE_W+1)'(p.im * p.im);
    endfunction

    function automatic wide_phasor_t widen(input phasor_t p);
        widen.re = WIDE_W'(p.re);
        widen.im = WIDE_W'(p.im);
    endfunction

endpackage

// ==== hdl/seq_directional_overcurrent.sv ====
// Sequence-current directional overcurrent element with current reversal logic
module seq_directional_overcurrent
    import seq_dir_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_in,
    // Phasor samples from the measurement source
    input wire logic sample_valid_in,
    input wire phasor_t v2_in,
    input wire phasor_t i2_in,
    input wire logic [PH_W-1:0] i0_mag_in,
    input wire logic [PH_W-1:0] i1_mag_in,
    input wire logic [PH_W-1:0] i2_mag_in,
    // Settings
    input wire seq_mode_t sequence_select_in,
    input wire logic [9:0] restraint_factor_in,
    input wire logic [PH_W-1:0] offset_impedance_in,
    input wire logic signed [PH_W-1:0] characteristic_angle_cos_in,
    input wire logic signed [PH_W-1:0] characteristic_angle_sin_in,
    input wire logic [PH_W-1:0] forward_limit_angle_cos_in,
    input wire logic [PH_W-1:0] reverse_limit_angle_cos_in,
    input wire logic [PH_W-1:0] forward_pickup_in,
    input wire logic [PH_W-1:0] reverse_pickup_in,
    input wire logic [PH_W-1:0] polarizing_voltage_threshold_in,
    // Indications
    output logic forward_indication_out,
    output logic reverse_indication_out,
    output logic polarizing_valid_out
);

    // ******************************************************************
    // Overcurrent unit
    // ******************************************************************
    logic [PH_W-1:0] sel_mag;
    logic [OP_W-3:0] restraint_x1000;
    logic signed [OP_W-1:0] op_x1000;
    logic signed [OP_W-1:0] fwd_pick_x1000;
    logic signed [OP_W-1:0] rev_pick_x1000;
    logic fwd_oc;
    logic rev_oc;

    always_comb begin
        sel_mag = (sequence_select_in == SEQ_ZERO) ? i0_mag_in : i2_mag_in;
        // Scaled by 1000 so K in thousandths needs no divider
        restraint_x1000 = (restraint_factor_in == 10'h000) ? 26'h0000000
                        : 26'(restraint_factor_in) * 26'(i1_mag_in);
        op_x1000 = $signed({2'b00, 26'(sel_mag) * K_SCALE}) - $signed({2'b00, restraint_x1000});
        fwd_pick_x1000 = $signed({2'b00, 26'(forward_pickup_in) * K_SCALE});
        rev_pick_x1000 = $signed({2'b00, 26'(reverse_pickup_in) * K_SCALE});
        fwd_oc = op_x1000 > fwd_pick_x1000;
        rev_oc = op_x1000 > rev_pick_x1000;
    end

    // ******************************************************************
    // Directional unit
    // ******************************************************************
    wide_phasor_t op_ph;
    wide_phasor_t pol_fwd;
    wide_phasor_t pol_rev;
    wide_phasor_t v2_w;
    logic signed [2*PH_W+1:0] rot_re;
    logic signed [2*PH_W+1:0] rot_im;
    logic signed [2*PH_W:0] z_re;
    logic signed [2*PH_W:0] z_im;
    logic pol_ok;
    logic fwd_dir;
    logic rev_dir;
    logic fwd_cand;
    logic rev_cand;

    always_comb begin
        v2_w = widen(v2_in);
        // Large offsets with large currents wrap; offsets stay small in practice
        z_re = $signed({1'b0, offset_impedance_in}) * i2_in.re;
        z_im = $signed({1'b0, offset_impedance_in}) * i2_in.im;
        op_ph.re = WIDE_W'(z_re >>> Z_SHIFT) - v2_w.re;
        op_ph.im = WIDE_W'(z_im >>> Z_SHIFT) - v2_w.im;
        // Full product width before the shift, a narrower sum would wrap
        rot_re = i2_in.re * characteristic_angle_cos_in - i2_in.im * characteristic_angle_sin_in;
        rot_im = i2_in.re * characteristic_angle_sin_in + i2_in.im * characteristic_angle_cos_in;
        pol_fwd.re = WIDE_W'(rot_re >>> ANG_FRAC);
        pol_fwd.im = WIDE_W'(rot_im >>> ANG_FRAC);
        // Shift by 180 degrees is a plain negation
        pol_rev.re = -pol_fwd.re;
        pol_rev.im = -pol_fwd.im;
        pol_ok = mag2(v2_w) > (2*WIDE_W+1)'(polarizing_voltage_threshold_in
                 * polarizing_voltage_threshold_in);
    end

    seq_angle_window u_fwd_window (
        .op_in(op_ph),
        .pol_in(pol_fwd),
        .limit_cos_in(forward_limit_angle_cos_in),
        .inside_out(fwd_dir)
    );

    seq_angle_window u_rev_window (
        .op_in(op_ph),
        .pol_in(pol_rev),
        .limit_cos_in(reverse_limit_angle_cos_in),
        .inside_out(rev_dir)
    );

    assign fwd_cand = pol_ok && fwd_oc && fwd_dir;
    assign rev_cand = pol_ok && rev_oc && rev_dir;

    // ******************************************************************
    // Current reversal logic and outputs
    // ******************************************************************
    rev_state_t state_q;
    rev_state_t state_d;
    logic [CNT_W-1:0] rev_streak_q;
    logic [CNT_W-1:0] rev_streak_d;
    logic [CNT_W-1:0] fwd_wait_q;
    logic [CNT_W-1:0] fwd_wait_d;
    dir_pair_t out_q;
    dir_pair_t out_d;
    logic pol_q;
    logic pol_d;
    logic fwd_release;

    // Counts saturate, samples arrive at a fixed rate per cycle
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        sat_inc = (v == 8'hff) ? v : v + 8'h01;
    endfunction

    always_comb begin
        state_d = state_q;
        rev_streak_d = rev_streak_q;
        fwd_wait_d = fwd_wait_q;
        out_d = out_q;
        pol_d = pol_q;
        fwd_release = (state_q != REV_ARMED) || (fwd_wait_q >= FWD_DELAY_COUNT);
        if (sample_valid_in) begin
            rev_streak_d = rev_cand ? sat_inc(rev_streak_q) : CNT_RESET;
            fwd_wait_d = (fwd_cand && state_q == REV_ARMED) ? sat_inc(fwd_wait_q) : CNT_RESET;
            pol_d = pol_ok;
            out_d.rev = rev_cand;
            out_d.fwd = fwd_cand && fwd_release;
            unique case (state_q)
                REV_IDLE: begin
                    if (rev_cand && rev_streak_q >= REV_ARM_COUNT - 8'h01) begin
                        state_d = REV_ARMED;
                    end
                end
                REV_ARMED: begin
                    if (fwd_cand && fwd_release) begin
                        state_d = REV_IDLE;
                    end
                end
                default: begin
                    state_d = REV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            state_q <= REV_IDLE;
            rev_streak_q <= CNT_RESET;
            fwd_wait_q <= CNT_RESET;
            out_q <= DIR_RESET;
            pol_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rev_streak_q <= rev_streak_d;
            fwd_wait_q <= fwd_wait_d;
            out_q <= out_d;
            pol_q <= pol_d;
        end
    end

    assign forward_indication_out = out_q.fwd;
    assign reverse_indication_out = out_q.rev;
    assign polarizing_valid_out = pol_q;

    // ******************************************************************
    // Assertions
    // ******************************************************************
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    a_pol_blocks_out: assert property (!polarizing_valid_out
        |-> !forward_indication_out && !reverse_indication_out)
        else $error("indication while polarizing voltage invalid");
    a_pol_threshold: assert property (sample_valid_in && !pol_ok |=> !polarizing_valid_out)
        else $error("polarizing valid below threshold");
    a_dir_exclusive: assert property (!(forward_indication_out && reverse_indication_out))
        else $error("forward and reverse together");
    a_fwd_cause: assert property ($rose(forward_indication_out)
        |-> $past(sample_valid_in && fwd_oc && fwd_dir))
        else $error("forward without pickup and direction");
    a_rev_follow: assert property (sample_valid_in && rev_cand |=> reverse_indication_out)
        else $error("reverse not indicated");
    a_k_zero_plain: assert property (restraint_factor_in == 10'h000
        |-> op_x1000 == $signed({2'b00, 26'(sel_mag) * K_SCALE}))
        else $error("zero restraint still subtracts");
    a_zero_mode_mag: assert property (sequence_select_in == SEQ_ZERO && i0_mag_in != i2_mag_in
        |-> sel_mag == i0_mag_in)
        else $error("zero mode not using zero sequence");
    a_arm_entry: assert property (state_q == REV_IDLE && sample_valid_in && rev_cand
        && rev_streak_q == REV_ARM_COUNT - 8'h01 |=> state_q == REV_ARMED)
        else $error("reversal logic not armed");
    a_armed_fwd_held: assert property (state_q == REV_ARMED && fwd_wait_q < FWD_DELAY_COUNT
        |=> !forward_indication_out)
        else $error("forward not delayed after reversal");
    a_fwd_pickup: assert property (sample_valid_in && !fwd_oc |=> !forward_indication_out)
        else $error("forward below pickup");

endmodule

// ==== testbench/phasor_source.sv ====
// Upstream phasor source model
module phasor_source
    import seq_dir_pkg::*;
(
    // Clock
    input wire logic clk_in,
    // Samples
    output logic valid_out,
    output phasor_t v2_out,
    output phasor_t i2_out,
    output logic [3*PH_W-1:0] mags_out
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        valid_out = 1'b0;
        {v2_out, i2_out, mags_out} = '0;
    end
    // One sample per call, then gap idle cycles
    task automatic send(input phasor_t v, input phasor_t c, input logic [3*PH_W-1:0] m, input int gap);
        valid_out = 1'b1;
        v2_out = v;
        i2_out = c;
        mags_out = m;
        @(posedge clk_in);
        #1;
        if (gap > 0) begin
            valid_out = 1'b0;
            // Stale values scrambled so nothing leans on them
            {v2_out, i2_out, mags_out} = ~{v, c, m};
            repeat (gap) begin
                @(posedge clk_in);
                #1;
            end
        end
    endtask
endmodule

// ==== testbench/seq_directional_overcurrent_test.sv ====
// Self-checking bench for the sequence directional overcurrent element
module seq_directional_overcurrent_test
    import seq_dir_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_in, rst_in, sv, fwd_o, rev_o, pol_o, seen_q;
    phasor_t v2, i2;
    logic [3*PH_W-1:0] mags;
    logic [PH_W-1:0] z, lim_f, lim_r, pk_f, pk_r, thr;
    logic signed [PH_W-1:0] ca_cos, ca_sin;
    seq_mode_t mode;
    logic [9:0] k;
    logic [2:0] expq[$];
    logic [2:0] e_now;
    int n_mismatch = 0, total_checks = 0, streak = 0, wait_n = 0;
    bit armed = 0, near;
    real th;

    seq_directional_overcurrent seq_directional_overcurrent_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .sample_valid_in(sv), .v2_in(v2), .i2_in(i2), .i0_mag_in(mags[47:32]), .i1_mag_in(mags[31:16]),
        .i2_mag_in(mags[15:0]), .sequence_select_in(mode), .restraint_factor_in(k), .offset_impedance_in(z),
        .characteristic_angle_cos_in(ca_cos), .characteristic_angle_sin_in(ca_sin),
        .forward_limit_angle_cos_in(lim_f), .reverse_limit_angle_cos_in(lim_r), .forward_pickup_in(pk_f),
        .reverse_pickup_in(pk_r), .polarizing_voltage_threshold_in(thr), .forward_indication_out(fwd_o),
        .reverse_indication_out(rev_o), .polarizing_valid_out(pol_o));
    phasor_source phasor_source_i (.clk_in(ref_clk_in), .valid_out(sv), .v2_out(v2), .i2_out(i2),
        .mags_out(mags));

    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end

    // Returns {pol, fwd, rev}; near flags samples too close to an edge to judge
    function automatic logic [2:0] predict(input phasor_t v, input phasor_t c, input logic [47:0] m,
                                           output bit nr);
        real ar, ai, br, bi, d, ab, op, lf, lr;
        bit pol, fc, rc, fe;
        ar = real'(z) * real'(c.re) / 256.0 - real'(v.re);
        ai = real'(z) * real'(c.im) / 256.0 - real'(v.im);
        br = (real'(c.re) * real'(ca_cos) - real'(c.im) * real'(ca_sin)) / 32768.0;
        bi = (real'(c.re) * real'(ca_sin) + real'(c.im) * real'(ca_cos)) / 32768.0;
        d = ar * br + ai * bi;
        ab = $sqrt((ar * ar + ai * ai) * (br * br + bi * bi));
        lf = real'(lim_f) / 32768.0;
        lr = real'(lim_r) / 32768.0;
        op = real'(mode == SEQ_ZERO ? m[47:32] : m[15:0]) * 1000.0 - real'(k) * real'(m[31:16]);
        pol = real'(v.re) ** 2 + real'(v.im) ** 2 > real'(thr) ** 2;
        fc = pol && op > real'(pk_f) * 1000.0 && d > lf * ab;
        rc = pol && op > real'(pk_r) * 1000.0 && -d > lr * ab;
        nr = (d - lf * ab) ** 2 < (0.03 * ab + 100.0) ** 2 || (d + lr * ab) ** 2 < (0.03 * ab + 100.0) ** 2;
        if (nr)
            return 3'h0;
        fe = fc && (!armed || wait_n >= int'(FWD_DELAY_COUNT));
        if (armed)
            wait_n = fc ? (fe ? 0 : wait_n + 1) : 0;
        if (fe)
            armed = 0;
        if (rc && streak >= int'(REV_ARM_COUNT) - 1)
            armed = 1;
        streak = rc ? streak + 1 : 0;
        return {pol, fe, rc};
    endfunction

    task automatic sample(input phasor_t v, input phasor_t c, input logic [47:0] m, input int gap);
        logic [2:0] e;
        e = predict(v, c, m, near);
        if (!near) begin
            expq.push_back(e);
            phasor_source_i.send(v, c, m, gap);
        end
    endtask

    task automatic compare(input string what, input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic do_reset();
        rst_in = 1'b1;
        repeat (20) @(posedge ref_clk_in);
        #1;
        rst_in = 1'b0;
        {streak, wait_n, armed} = '0;
        @(posedge ref_clk_in);
        #1;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ******************************************************************
    // Result monitor, one cycle after each taken sample
    // ******************************************************************
    always @(posedge ref_clk_in) seen_q <= sv;
    always @(negedge ref_clk_in) begin
        if (seen_q === 1'b1 && rst_in === 1'b0) begin
            e_now = (expq.size() > 0) ? expq.pop_front() : 3'bxxx;
            compare("pol", pol_o, e_now[2]);
            compare("fwd", fwd_o, e_now[1]);
            compare("rev", rev_o, e_now[0]);
        end
    end

    initial begin
        #50us;
        n_mismatch++;
        finish_test();
    end

    initial begin
        {k, z, ca_sin} = '0;
        mode = SEQ_NEG;
        {ca_cos, lim_f, lim_r} = {16'h7fff, 16'h4000, 16'h4000};
        {pk_f, pk_r, thr} = {16'h0064, 16'h0064, 16'h0064};
        void'($urandom(61));
        do_reset();
        // Back to back: 80 reverse arm, 79 reverse do not
        for (int n = 0; n < 280; n++)
            sample({16'hfc18, 16'h0000}, (n < 80 || (n >= 180 && n < 259)) ? {16'hfc18, 16'h0000}
                   : {16'h03e8, 16'h0000}, {16'h0000, 16'h0000, 16'h07d0}, n == 279 ? 2 : 0);
        do_reset();
        for (int n = 0; n < 400; n++) begin
            do begin
                mode = seq_mode_t'($urandom_range(1));
                k = ($urandom_range(3) == 0) ? 10'h000 : 10'($urandom_range(500));
                z = 16'($urandom_range(255));
                th = (real'($urandom_range(180)) - 90.0) * 3.14159265 / 180.0;
                ca_cos = 16'($rtoi(32767.0 * $cos(th)));
                ca_sin = 16'($rtoi(32767.0 * $sin(th)));
                lim_f = 16'($rtoi(32768.0 * $cos(real'($urandom_range(40, 90)) * 3.14159265 / 180.0)));
                lim_r = 16'($rtoi(32768.0 * $cos(real'($urandom_range(40, 90)) * 3.14159265 / 180.0)));
                {pk_f, pk_r, thr} = {16'($urandom_range(3000)), 16'($urandom_range(3000)), 16'($urandom_range(3000))};
                sample({16'($urandom_range(8000)) - 16'h0fa0, 16'($urandom_range(8000)) - 16'h0fa0},
                       {16'($urandom_range(8000)) - 16'h0fa0, 16'($urandom_range(8000)) - 16'h0fa0},
                       {16'($urandom_range(4000)), 16'($urandom_range(4000)), 16'($urandom_range(4000))},
                       n == 399 ? 2 : 1);
            end while (near);
        end
        repeat (3) @(posedge ref_clk_in);
        compare("queue", expq.size() == 0, 1'b1);
        finish_test();
    end
endmodule
